// file: async_handshake_bus_read_cycle_bench.sv
/*
 * self-checking bench for the read sequencer with a slave model.
 * assumes 200 MHz system clock and the bus clock and codes of rdbus_cfg.svh.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rdbus_cfg.svh"

module async_handshake_bus_read_cycle_bench;
    logic clk_sys_i = 1'b0;         // system clock
    logic rst_i = 1'b1;             // synchronous reset
    logic req_valid = 1'b0;         // request to the sequencer
    rdbus_pkg::rd_req_t req = '0;   // request fields
    rdbus_pkg::cs_cfg_t cfg = '0;   // chip-select options
    rdbus_pkg::rd_result_t result;  // captured result
    logic req_ready, done, bus_clk, rd_wr, as_n, ds_n, oe_n;
    logic ack_b_n, ack_w_n, fault_n, halt_n;
    logic [23:0] addr;
    logic [2:0] space;
    logic [1:0] size;
    logic [15:0] data_in, data_out;
    logic [3:0] s_wait = 4'h0;      // slave options
    logic s_aen = 1'b1;
    logic s_p16 = 1'b1;
    logic s_flt = 1'b0;
    logic s_hlt = 1'b0;
    logic [15:0] s_word = 16'h0000;
    int mismatches = 0;
    int checked = 0;
    int cycles = 0;

    rdbus_master u_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .req_valid_i(req_valid),
        .req_i(req), .cs_cfg_i(cfg), .req_ready_o(req_ready), .done_o(done),
        .result_o(result), .system_clock_out_o(bus_clk), .addr_o(addr),
        .space_select_code_o(space), .transfer_size_out_o(size), .rd_wr_o(rd_wr),
        .addr_valid_strobe_n_o(as_n), .data_valid_strobe_n_o(ds_n), .data_bus_i(data_in),
        .data_bus_o(data_out), .data_bus_oe_n_o(oe_n), .port_ack_byte_wide_n_i(ack_b_n),
        .port_ack_word_wide_n_i(ack_w_n), .bus_fault_in_n_i(fault_n), .halt_n_i(halt_n));

    bus_slave_model u_slave (.clk_sys_i(clk_sys_i), .bus_clk_i(bus_clk),
        .data_valid_strobe_n_i(ds_n), .wait_i(s_wait), .ack_en_i(s_aen), .port16_i(s_p16),
        .fault_i(s_flt), .halt_i(s_hlt), .word_i(s_word),
        .port_ack_byte_wide_n_o(ack_b_n), .port_ack_word_wide_n_o(ack_w_n),
        .bus_fault_in_n_o(fault_n), .halt_n_o(halt_n), .data_o(data_in));

    // free-running system clock
    initial
    begin
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end

    // hang guard, far above the few hundred cycles the run needs
    always @(posedge clk_sys_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    // one read: p16 is the port width in force, len the strobe-low cycles
    task automatic run_read(input logic [23:0] a, input logic [1:0] sz, input logic [2:0] sp,
        input rdbus_pkg::cs_cfg_t c, input logic [3:0] w, input logic aen, input logic p16,
        input logic flt, input logic [15:0] word, input int len);
        int n;
        logic [15:0] mask;
        logic [15:0] exp;
        req = '{addr: a, size: sz, space: sp};
        cfg = c;
        s_wait = w;
        s_aen = aen;
        s_p16 = p16;
        s_flt = flt;
        s_word = word;
        req_valid = 1'b1;
        mask = p16 ? 16'hFFFF : 16'hFF00;
        exp = word;
        // byte lane chosen by lane bit and port width
        if (sz == `SIZE_BYTE)
        begin
            mask = 16'h00FF;
            exp = (!p16 || !a[0]) ? {8'h00, word[15:8]} : {8'h00, word[7:0]};
        end
        n = 0;
        while (as_n !== 1'b0 && n < 100)
        begin
            @(negedge clk_sys_i);
            n++;
        end
        check("data strobe in S1", ds_n, 1'b0);
        check("address", addr, a);
        check("space code", space, sp);
        check("size code", size, sz);
        check("read level", rd_wr, 1'b1);
        check("bus released", {oe_n, data_out}, 17'h10000);
        n = 0;
        do
        begin
            @(negedge clk_sys_i);
            n++;
        end while (as_n === 1'b0 && n < 200);
        check("strobe low cycles", n, len);
        check("data strobe in S5", ds_n, 1'b1);
        check("address in S5", {addr, size, space}, {a, sz, sp});
        n = 0;
        while (done !== 1'b1 && n < 20)
        begin
            @(negedge clk_sys_i);
            n++;
        end
        req_valid = 1'b0;
        check("done", done, 1'b1);
        check("ready with done", req_ready, 1'b1);
        check("fault flag", result.fault, flt);
        if (!flt)
        begin
            check("read data", result.data & mask, exp & mask);
            check("port width", result.port16, p16);
        end
        repeat (3) @(negedge clk_sys_i);
    endtask

    // external ack with no waits, then one to three waits
    task automatic s_waits();
        for (int w = 0; w < 4; w++)
            run_read(24'h012346, `SIZE_WORD, 3'h5, '0, w[3:0], 1'b1, 1'b1, 1'b0,
                16'hA55A, 8 + 4 * w);
    endtask

    // lanes for byte, word and long sizes, both port widths and lane bits, every space code but 5
    task automatic s_lanes();
        run_read(24'h000100, `SIZE_BYTE, 3'h0, '0, 4'h0, 1'b1, 1'b1, 1'b0, 16'hC312, 8);
        run_read(24'h000101, `SIZE_BYTE, 3'h1, '0, 4'h0, 1'b1, 1'b1, 1'b0, 16'hC312, 8);
        run_read(24'hFFFFFF, `SIZE_BYTE, 3'h2, '0, 4'h0, 1'b1, 1'b0, 1'b0, 16'h5E81, 8);
        run_read(24'h800000, `SIZE_WORD, 3'h3, '0, 4'h0, 1'b1, 1'b0, 1'b0, 16'h9A3C, 8);
        run_read(24'h7FFFFE, `SIZE_LONG, 3'h4, '0, 4'h0, 1'b1, 1'b1, 1'b0, 16'h1E2D, 8);
        run_read(24'h2468AC, `SIZE_WORD, 3'h6, '0, 4'h0, 1'b1, 1'b1, 1'b0, 16'h0FF0, 8);
        run_read(24'h13579A, `SIZE_WORD, 3'h7, '0, 4'h0, 1'b1, 1'b1, 1'b0, 16'hF00F, 8);
    endtask

    // internal ack and fast termination, with the slave never acking
    // reads only, one chip select matched per cycle
    task automatic s_internal();
        run_read(24'h040004, `SIZE_WORD, 3'h5, '{1'b1, 1'b0, 1'b0, 4'h2}, 4'h0, 1'b0, 1'b0,
            1'b0, 16'h2DB4, 16);
        run_read(24'h040000, `SIZE_WORD, 3'h5, '{1'b1, 1'b0, 1'b1, 4'h0}, 4'h0, 1'b0, 1'b1,
            1'b0, 16'h6B2D, 8);
        run_read(24'h040002, `SIZE_WORD, 3'h5, '{1'b1, 1'b1, 1'b1, 4'h0}, 4'h0, 1'b0, 1'b1,
            1'b0, 16'h3C96, 4);
    endtask

    // late bus fault after the acknowledge
    task automatic s_fault();
        run_read(24'h00F000, `SIZE_WORD, 3'h1, '0, 4'h0, 1'b1, 1'b1, 1'b1, 16'h4444, 8);
    endtask

    // fault with halt: no done, the cycle reruns and then ends normally
    task automatic s_retry();
        int n;
        logic rerun;
        req = '{addr: 24'h000300, size: `SIZE_WORD, space: 3'h2};
        cfg = '0;
        s_wait = 4'h0;
        s_aen = 1'b1;
        s_p16 = 1'b1;
        s_flt = 1'b1;
        s_hlt = 1'b1;
        s_word = 16'h7E81;
        req_valid = 1'b1;
        n = 0;
        while (as_n !== 1'b0 && n < 100)
        begin
            @(negedge clk_sys_i);
            n++;
        end
        while (as_n !== 1'b1 && n < 200)
        begin
            @(negedge clk_sys_i);
            n++;
        end
        // the rerun sees a clean slave
        s_flt = 1'b0;
        s_hlt = 1'b0;
        rerun = 1'b0;
        while (done !== 1'b1 && n < 300)
        begin
            @(negedge clk_sys_i);
            rerun = rerun | (as_n === 1'b0);
            n++;
        end
        req_valid = 1'b0;
        check("cycle rerun before done", rerun, 1'b1);
        check("done after retry", done, 1'b1);
        check("retry fault flag", result.fault, 1'b0);
        check("retry data", result.data, 16'h7E81);
        repeat (3) @(negedge clk_sys_i);
    endtask

    // reset in mid-cycle, then a cycle must run normally again
    task automatic s_reset_mid();
        int n;
        req = '{addr: 24'h000200, size: `SIZE_WORD, space: 3'h5};
        req_valid = 1'b1;
        n = 0;
        while (as_n !== 1'b0 && n < 100)
        begin
            @(negedge clk_sys_i);
            n++;
        end
        rst_i = 1'b1;
        req_valid = 1'b0;
        repeat (2) @(negedge clk_sys_i);
        check("strobes in reset", {as_n, ds_n}, 2'h3);
        check("bus released", oe_n, 1'b1);
        check("no done in reset", done, 1'b0);
        rst_i = 1'b0;
        repeat (4) @(negedge clk_sys_i);
        check("idle after reset", as_n, 1'b1);
        run_read(24'h000204, `SIZE_WORD, 3'h5, '0, 4'h1, 1'b1, 1'b1, 1'b0, 16'h8421, 12);
    endtask

    // main sequence, inputs changed at falling edges only
    initial
    begin
        repeat (4) @(negedge clk_sys_i);
        rst_i = 1'b0;
        @(negedge clk_sys_i);
        s_waits();
        s_lanes();
        s_internal();
        s_fault();
        s_retry();
        s_reset_mid();
        report_and_stop();
    end

endmodule

`default_nettype wire

// file: bus_slave_model.sv
/*
 * behavioural memory slave facing the read sequencer: acknowledges after a
 * set number of bus-clock falling edges and drives lanes by its port width.
 * assumes the bench changes its options only between bus cycles.
 */
`timescale 1ns/1ps
`default_nettype none

module bus_slave_model (
    input  wire logic        clk_sys_i,
    input  wire logic        bus_clk_i,
    input  wire logic        data_valid_strobe_n_i,
    input  wire logic [3:0]  wait_i,
    input  wire logic        ack_en_i,
    input  wire logic        port16_i,
    input  wire logic        fault_i,
    input  wire logic        halt_i,
    input  wire logic [15:0] word_i,
    output var  logic        port_ack_byte_wide_n_o,
    output var  logic        port_ack_word_wide_n_o,
    output var  logic        bus_fault_in_n_o,
    output var  logic        halt_n_o,
    output var  logic [15:0] data_o
);
    logic       clk_d_q;  // bus clock one system cycle ago
    logic [3:0] fall_q;   // bus falling edges since the high half of S0
    logic [4:0] eff;      // count including an edge seen just now
    logic       ready;    // selected and data access time elapsed
    logic       ack_on;   // acknowledge asserted

    // cleared in every high half outside a cycle, so counts never drift
    always_ff @(posedge clk_sys_i)
    begin
        clk_d_q <= bus_clk_i;
        if (data_valid_strobe_n_i && bus_clk_i)
            fall_q <= 4'h0;
        else if (clk_d_q && !bus_clk_i && fall_q != 4'hF)
            fall_q <= fall_q + 4'h1;
    end

    // the edge that starts S1 counts one, so waits equal wait_i
    always_comb
    begin
        eff = {1'b0, fall_q} + {4'h0, clk_d_q && !bus_clk_i};
        ready = !data_valid_strobe_n_i && (eff > {1'b0, wait_i});
        ack_on = ready && ack_en_i;
    end

    // ack held off, then held until strobe negates
    assign port_ack_word_wide_n_o = !(ack_on && port16_i);
    assign port_ack_byte_wide_n_o = !(ack_on && !port16_i);
    // fault one bus clock after ack, before S4 end
    assign bus_fault_in_n_o = !(ack_on && fault_i && (eff > {1'b0, wait_i} + 5'h1));
    // halt rides with the late fault, asking for a retry
    assign halt_n_o = !(ack_on && halt_i && (eff > {1'b0, wait_i} + 5'h1));
    // lanes driven at once, released lanes show the inverse
    assign data_o[15:8] = ready ? word_i[15:8] : ~word_i[15:8];
    assign data_o[7:0] = (ready && port16_i) ? word_i[7:0] : ~word_i[7:0];

endmodule

`default_nettype wire

// file: rdbus_cfg.svh
/*
 * constants for the external read-cycle sequencer: bus timing, size codes,
 * pin widths and reset values.
 * assumes it is included by bare name from the package, the sequencer and the bench.
 */
`ifndef RDBUS_CFG_SVH
`define RDBUS_CFG_SVH

// system clock and external bus clock periods, in ns
`define SYS_CLK_PERIOD_NS   5
`define BUS_CLK_PERIOD_NS   20
// system cycles per half bus clock (one bus state), at least one
`define BUS_HALF_CYC        ((`BUS_CLK_PERIOD_NS / (2 * `SYS_CLK_PERIOD_NS)) < 1 ? 1 : \
                             (`BUS_CLK_PERIOD_NS / (2 * `SYS_CLK_PERIOD_NS)))

// bus widths
`define ADDR_W              24
`define DATA_W              16
`define SPACE_W             3
`define WAIT_W              4

// transfer size output codes
`define SIZE_LONG           2'h0
`define SIZE_BYTE           2'h1
`define SIZE_WORD           2'h2
`define SIZE_TRIPLE         2'h3

// reset values of the bus pins
`define ADDR_RST            24'h000000
`define DATA_RST            16'h0000
`define SPACE_RST           3'h0
`define STROBE_RST          1'h1

`endif

// file: rdbus_master.sv
/*
 * external bus master read-cycle sequencer, states S0 to S5 with wait states,
 * internal or external acknowledge and fast termination.
 * assumes clk_sys_i is the only clock; all bus pins are asynchronous and are
 * brought in through two flip-flops; the core holds req_i while req_valid_i.
 */
// Overview of operation
// - data captured one falling edge after acknowledge
// - acknowledged cycle lasts at least three clocks
// - acknowledge at end of S2 means no waits
// - fast termination finishes in two clocks
// - option picks internal or external acknowledge
// - fast cycles drive data strobe on reads only
// - separate 24-bit address and 16-bit data lines
// - byte or two-byte read, lane by size
// - S0 drives address, space code, read, size
// - both strobes asserted in S1
// - no acknowledge by S2 end inserts waits
// - waits sample acknowledge on every falling edge
// - read data captured at end of S4
// - S5 negates strobes, holds address and codes
// - acknowledge pair reports 8 or 16-bit port
// - fault aborts, fault with halt retries
`timescale 1ns/1ps
`default_nettype none
`include "rdbus_cfg.svh"

module rdbus_master (
    input  wire logic                   clk_sys_i,
    input  wire logic                   rst_i,
    input  wire logic                   req_valid_i,
    input  wire rdbus_pkg::rd_req_t     req_i,
    input  wire rdbus_pkg::cs_cfg_t     cs_cfg_i,
    output var  logic                   req_ready_o,
    output var  logic                   done_o,
    output var  rdbus_pkg::rd_result_t  result_o,
    output var  logic                   system_clock_out_o,
    output var  logic [`ADDR_W-1:0]     addr_o,
    output var  logic [`SPACE_W-1:0]    space_select_code_o,
    output var  logic [1:0]             transfer_size_out_o,
    output var  logic                   rd_wr_o,
    output var  logic                   addr_valid_strobe_n_o,
    output var  logic                   data_valid_strobe_n_o,
    input  wire logic [`DATA_W-1:0]     data_bus_i,
    output var  logic [`DATA_W-1:0]     data_bus_o,
    output var  logic                   data_bus_oe_n_o,
    input  wire logic                   port_ack_byte_wide_n_i,
    input  wire logic                   port_ack_word_wide_n_i,
    input  wire logic                   bus_fault_in_n_i,
    input  wire logic                   halt_n_i
);

    localparam int HALF    = `BUS_HALF_CYC;   // sys cycles per bus state
    localparam int CAP_DLY = 2 * HALF;        // ack edge to capture edge
    localparam int CNT_W   = (HALF > 1) ? $clog2(HALF) : 1;
    localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(HALF - 1);

    rdbus_pkg::bus_st_t     st_q;            // sequencer state
    logic [CNT_W-1:0]       div_q;           // half-clock divider
    logic                   tick;            // last sys cycle of a bus state
    logic                   fall;            // tick on a falling bus edge
    logic [`DATA_W-1:0]     din_m_q;         // data bus, first stage
    logic [`DATA_W-1:0]     din_q;           // data bus, second stage
    logic [3:0]             ctl_m_q;         // ack/fault/halt, first stage
    logic [3:0]             ctl_q;           // ack/fault/halt, second stage
    logic                   ack_byte;        // 8-bit port acknowledge seen
    logic                   ack_word;        // 16-bit port acknowledge seen
    logic                   fault_in;        // bus fault seen
    logic                   halt_in;         // halt seen
    logic [`WAIT_W-1:0]     wcnt_q;          // shared wait-state counter
    logic                   ack_seen_q;      // termination recognized
    logic                   ack_rec;         // recognition edge this cycle
    logic                   ack_now;         // acknowledge source result
    logic                   fault_q;         // fault recognized in this cycle
    logic                   port16_q;        // port width of this cycle
    rdbus_pkg::rd_req_t     cur_q;           // request being served
    rdbus_pkg::cs_cfg_t     cfg_q;           // options of this cycle

    // bus clock divider: one tick ends each half bus clock
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            div_q              <= '0;
            system_clock_out_o <= 1'b0;
        end
        else if (div_q == HALF_LAST)
        begin
            div_q              <= '0;
            system_clock_out_o <= ~system_clock_out_o;
        end
        else
        begin
            div_q <= div_q + 1'b1;
        end
    end

    assign tick = (div_q == HALF_LAST);
    assign fall = tick && system_clock_out_o;

    // two-stage synchronisers for every bus input; only stage two is read
    // deskew slave inputs
    always_ff @(posedge clk_sys_i)
    begin
        din_m_q <= data_bus_i;
        din_q   <= din_m_q;
        ctl_m_q <= {~halt_n_i, ~bus_fault_in_n_i,
                    ~port_ack_word_wide_n_i, ~port_ack_byte_wide_n_i};
        ctl_q   <= ctl_m_q;
    end

    assign ack_byte = ctl_q[0];
    assign ack_word = ctl_q[1];
    assign fault_in = ctl_q[2];
    assign halt_in  = ctl_q[3];

    // acknowledge source: internal count or the external pair
    always_comb
    begin
        if (cfg_q.ack_internal)
            ack_now = (wcnt_q == '0);
        else
            ack_now = ack_byte || ack_word;
    end

    // recognition happens on the falling edges that end S2 and wait states
    // sample every falling edge
    assign ack_rec = fall && ((st_q == rdbus_pkg::ST_S2) || (st_q == rdbus_pkg::ST_WHI))
                     && (ack_now || fault_in);

    // sequencer state, one step per bus state
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
            st_q <= rdbus_pkg::ST_IDLE;
        else if (tick)
        begin
            case (st_q)
                // start S0 on a rising bus edge
                rdbus_pkg::ST_IDLE:
                    if (req_valid_i && !system_clock_out_o)
                        st_q <= rdbus_pkg::ST_S0;
                rdbus_pkg::ST_S0:
                    st_q <= rdbus_pkg::ST_S1;
                rdbus_pkg::ST_S1:
                    st_q <= cfg_q.fast_term ? rdbus_pkg::ST_S4 : rdbus_pkg::ST_S2;
                rdbus_pkg::ST_S2:
                    st_q <= rdbus_pkg::ST_S3;
                rdbus_pkg::ST_S3:
                    st_q <= ack_seen_q ? rdbus_pkg::ST_S4 : rdbus_pkg::ST_WHI;
                rdbus_pkg::ST_WHI:
                    st_q <= rdbus_pkg::ST_WLO;
                rdbus_pkg::ST_WLO:
                    st_q <= ack_seen_q ? rdbus_pkg::ST_S4 : rdbus_pkg::ST_WHI;
                rdbus_pkg::ST_S4:
                    st_q <= rdbus_pkg::ST_S5;
                rdbus_pkg::ST_S5:
                    st_q <= rdbus_pkg::ST_IDLE;
                default:
                    st_q <= rdbus_pkg::ST_IDLE;
            endcase
        end
    end

    // latch request and options when the cycle starts
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            cur_q <= '0;
            cfg_q <= '0;
        end
        else if (tick && st_q == rdbus_pkg::ST_IDLE && req_valid_i && !system_clock_out_o)
        begin
            cur_q <= req_i;
            cfg_q <= cs_cfg_i;
        end
    end

    // shared wait counter, loaded entering S2, counted down each falling edge;
    // one counter for all chip selects, so overlapping selects must agree
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
            wcnt_q <= '0;
        else if (tick && st_q == rdbus_pkg::ST_S1)
            wcnt_q <= cfg_q.wait_cnt;
        else if (fall && wcnt_q != '0)
            wcnt_q <= wcnt_q - 1'b1;
    end

    // termination bookkeeping: recognized ack, port width, fault
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i || (tick && st_q == rdbus_pkg::ST_S0))
        begin
            ack_seen_q <= 1'b0;
            port16_q   <= 1'b0;
            fault_q    <= 1'b0;
        end
        else if (tick && st_q == rdbus_pkg::ST_S1 && cfg_q.fast_term)
        begin
            // fast cycles end on an internal, clock-synchronous ack
            ack_seen_q <= 1'b1;
            port16_q   <= cfg_q.port16;
        end
        else if (ack_rec)
        begin
            ack_seen_q <= 1'b1;
            port16_q   <= cfg_q.ack_internal ? cfg_q.port16 : ack_word;
            fault_q    <= fault_in;
        end
        else if (fall && st_q == rdbus_pkg::ST_S4 && fault_in)
            fault_q <= 1'b1;
    end

    // address, space code, direction and size pins
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            addr_o              <= `ADDR_RST;
            space_select_code_o <= `SPACE_RST;
            transfer_size_out_o <= `SIZE_LONG;
            rd_wr_o             <= 1'b1;
        end
        else if (tick && st_q == rdbus_pkg::ST_IDLE && req_valid_i && !system_clock_out_o)
        begin
            addr_o              <= req_i.addr;
            space_select_code_o <= req_i.space;
            transfer_size_out_o <= req_i.size;
            rd_wr_o             <= 1'b1;
        end
    end

    // strobes: asserted at S1 start, negated at S5 start
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            addr_valid_strobe_n_o <= `STROBE_RST;
            data_valid_strobe_n_o <= `STROBE_RST;
        end
        else if (tick && st_q == rdbus_pkg::ST_S0)
        begin
            addr_valid_strobe_n_o <= 1'b0;
            data_valid_strobe_n_o <= 1'b0;
        end
        else if (tick && st_q == rdbus_pkg::ST_S4)
        begin
            addr_valid_strobe_n_o <= 1'b1;
            data_valid_strobe_n_o <= 1'b1;
        end
    end

    // data pins: a read-only master never drives the bus
    // bus released
    always_ff @(posedge clk_sys_i)
    begin
        data_bus_o      <= `DATA_RST;
        data_bus_oe_n_o <= 1'b1;
    end

    // capture data at the falling edge ending S4, aligned by size and lane
    // capture at S4 end
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
            result_o <= '0;
        else if (fall && st_q == rdbus_pkg::ST_S4)
        begin
            result_o.port16 <= port16_q;
            result_o.fault  <= fault_q || fault_in;
            if (cur_q.size == `SIZE_BYTE)
                result_o.data <= {8'h00, (!port16_q || !cur_q.addr[0]) ?
                                         din_q[15:8] : din_q[7:0]};
            else
                result_o.data <= port16_q ? din_q : {din_q[15:8], 8'h00};
        end
    end

    // handshake to the core: ready and done pulse together leaving S5;
    // a fault with halt repeats the cycle without reporting it
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            req_ready_o <= 1'b0;
            done_o      <= 1'b0;
        end
        else
        begin
            done_o      <= tick && st_q == rdbus_pkg::ST_S5 && !(result_o.fault && halt_in);
            req_ready_o <= tick && st_q == rdbus_pkg::ST_S5 && !(result_o.fault && halt_in);
        end
    end

    // checks: cycle length counter for the timing assertions
    int unsigned len_q;   // sys cycles since S0 entry

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i || (tick && st_q == rdbus_pkg::ST_IDLE))
            len_q <= 0;
        else if (st_q != rdbus_pkg::ST_IDLE)
            len_q <= len_q + 1;
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    sequence s2_ack_seq;
        fall && st_q == rdbus_pkg::ST_S2 && ack_now && !cfg_q.ack_internal;
    endsequence

    sequence s5_end_seq;
        tick && st_q == rdbus_pkg::ST_S5;
    endsequence

    AST_CAPTURE_NEXT_FALL: assert property (
        ack_rec |-> ##CAP_DLY (fall && st_q == rdbus_pkg::ST_S4))
        else $error("data not captured on the falling edge after acknowledge");
    AST_MIN_THREE_CLK: assert property (
        (s5_end_seq and !cfg_q.fast_term) |-> len_q >= 6 * HALF - 1)
        else $error("acknowledged cycle shorter than three clocks");
    AST_NO_WAIT: assert property (
        s2_ack_seq |=> (st_q == rdbus_pkg::ST_S3) ##HALF (st_q == rdbus_pkg::ST_S4))
        else $error("wait state inserted despite acknowledge at S2 end");
    AST_FAST_TWO: assert property (
        (s5_end_seq and cfg_q.fast_term) |-> len_q == 4 * HALF - 1)
        else $error("fast termination cycle not two clocks");
    AST_DS_READ_ONLY: assert property (
        !data_valid_strobe_n_o |-> rd_wr_o && !addr_valid_strobe_n_o)
        else $error("data strobe asserted outside a read");
    AST_STROBES_S1: assert property (
        $rose(st_q == rdbus_pkg::ST_S1) |-> (!addr_valid_strobe_n_o && !data_valid_strobe_n_o))
        else $error("strobes not asserted in S1");
    AST_S5_HOLD: assert property (
        (st_q == rdbus_pkg::ST_S5) |-> addr_valid_strobe_n_o && data_valid_strobe_n_o
            && $stable(addr_o) && $stable(transfer_size_out_o)
            && $stable(space_select_code_o) && rd_wr_o)
        else $error("S5 strobes or address wrong");
    AST_WAIT_INSERT: assert property (
        (tick && st_q == rdbus_pkg::ST_S3 && !ack_seen_q) |=> st_q == rdbus_pkg::ST_WHI)
        else $error("no wait state without acknowledge");
    AST_RESET_IDLE: assert property (
        $past(rst_i) |-> st_q == rdbus_pkg::ST_IDLE && addr_valid_strobe_n_o && data_bus_oe_n_o)
        else $error("sequencer not idle after reset");

endmodule
`default_nettype wire

// file: rdbus_pkg.sv
/*
 * types shared by the read-cycle sequencer: request, chip-select option,
 * result and sequencer states.
 * assumes rdbus_cfg.svh is on the include path.
 */
`include "rdbus_cfg.svh"

package rdbus_pkg;

    // one read request from the core side
    typedef struct packed {
        logic [`ADDR_W-1:0]  addr;   // byte address, bit 0 picks the lane
        logic [1:0]          size;   // transfer size code
        logic [`SPACE_W-1:0] space;  // address space code
    } rd_req_t;

    // option bits of the chip select that matches the request
    typedef struct packed {
        logic                ack_internal; // 1: internal acknowledge
        logic                fast_term;    // 1: two-clock transfer
        logic                port16;       // port width for internal ack
        logic [`WAIT_W-1:0]  wait_cnt;     // wait states for internal ack
    } cs_cfg_t;

    // result handed back when the cycle ends
    typedef struct packed {
        logic [`DATA_W-1:0]  data;       // lane-aligned read data
        logic                port16;     // 1: 16-bit port answered
        logic                fault;      // cycle ended by bus fault
    } rd_result_t;

    // bus states, each one half bus clock long except ST_IDLE, which lasts until a request starts S0
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_S0,
        ST_S1,
        ST_S2,
        ST_S3,
        ST_WHI,
        ST_WLO,
        ST_S4,
        ST_S5
    } bus_st_t;

endpackage
